// *** logic/t8pw_pkg.sv ***
// Register map, field positions, reset values and types of the 8-bit PWM timer.
package t8pw_pkg;
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] COUNT_OFS = 5'h04;
  localparam logic [4:0] CMP_OFS = 5'h08;
  localparam logic [4:0] FLAG_OFS = 5'h0C;
  localparam logic [4:0] CFG_OFS = 5'h10;

  localparam int FORCE_BIT = 7;
  localparam int WGM_LOW_BIT = 6;
  localparam int COM_HI_BIT = 5;
  localparam int COM_LO_BIT = 4;
  localparam int WGM_HIGH_BIT = 3;
  localparam int CS_HI_BIT = 2;
  localparam int CS_LO_BIT = 0;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMF_BIT = 1;
  localparam int CFG_ASYNC_BIT = 0;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;

  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_32 = 10'h01F;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_128 = 10'h07F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE = 2'h1,
    MODE_CTC = 2'h2,
    MODE_FAST = 2'h3
  } t8pw_mode_t;

  typedef enum logic [1:0] {
    ACT_OFF = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } t8pw_act_t;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } t8pw_avs_req_t;
endpackage

// *** logic/t8pw_prescaler.sv ***
// Tick divider that turns the selected source into the prescaled timer tick.
`timescale 1ns/1ps
module t8pw_prescaler
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic src_tick_in,
  input wire logic [2:0] select_in,
  output logic timer_tick_out
);
  import t8pw_pkg::*;

  typedef struct packed {
    logic [9:0] div;
  } t8pw_pre_state_t;

  t8pw_pre_state_t st_reg;
  t8pw_pre_state_t st_next;
  logic [9:0] mask;

  // The divider free-runs on source ticks, so changing the select
  // may shorten the first period; software rarely cares.
  always_comb
  begin
    st_next = st_reg;
    case (select_in)
      3'h1: mask = PRE_MASK_1;
      3'h2: mask = PRE_MASK_8;
      3'h3: mask = PRE_MASK_32;
      3'h4: mask = PRE_MASK_64;
      3'h5: mask = PRE_MASK_128;
      3'h6: mask = PRE_MASK_256;
      3'h7: mask = PRE_MASK_1024;
      default: mask = PRE_MASK_1;
    endcase
    if (src_tick_in)
    begin
      st_next.div = st_reg.div + 10'h001;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign timer_tick_out = src_tick_in & (select_in != CS_STOP)
    & ((st_reg.div & mask) == mask);
endmodule

// *** logic/t8pw_top.sv ***
// 8-bit timer with normal, clear-on-match and two PWM waveform modes.
`timescale 1ns/1ps
module t8pw_top
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire t8pw_pkg::t8pw_avs_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic osc_clk_in,
  input wire logic port_data_in,
  input wire logic overflow_ack_in,
  input wire logic compare_ack_in,
  output logic compare_output_pin_out,
  output logic compare_output_en_out,
  output logic overflow_flag_out,
  output logic compare_match_flag_out
);
  import t8pw_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [7:0] cmp_buf;
    logic [7:0] cmp_act;
    logic async_sel;
    logic ovf;
    logic cmf;
    logic dir_down;
    logic oc;
    logic block_match;
    logic pin;
    logic pin_en;
    logic bus_done;
    logic [31:0] rdata;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
  } t8pw_state_t;

  localparam t8pw_state_t ST_RST = '{
    ctrl: CTRL_RST,
    count: COUNT_RST,
    cmp_buf: CMP_RST,
    cmp_act: CMP_RST,
    default: '0
  };

  t8pw_state_t st_reg;
  t8pw_state_t st_next;
  t8pw_mode_t mode;
  t8pw_act_t act;
  logic timer_tick;
  logic src_tick;
  logic req_act;
  logic access;
  logic wr_en;
  logic [2:0] idx;
  logic [7:0] wdat;
  logic at_max;
  logic at_zero;
  logic match;
  logic up_eff;
  logic ovf_set;
  logic cmf_set;
  logic ovf_clr;
  logic cmf_clr;
  logic flag_wr;

  function automatic logic act_result(input t8pw_act_t a, input logic cur);
    case (a)
      ACT_TOGGLE: act_result = ~cur;
      ACT_CLEAR: act_result = 1'b0;
      ACT_SET: act_result = 1'b1;
      default: act_result = cur;
    endcase
  endfunction

  // Only the second and third stages of the oscillator synchroniser
  // feed the edge detect; the first stage metastability stays contained.
  assign src_tick = st_reg.async_sel ? (st_reg.osc_s2 & ~st_reg.osc_s3)
    : 1'b1;

  t8pw_prescaler u_prescaler
  (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .src_tick_in(src_tick),
    .select_in(st_reg.ctrl[CS_HI_BIT:CS_LO_BIT]),
    .timer_tick_out(timer_tick)
  );

  always_comb
  begin
    st_next = st_reg;
    req_act = avs_req_in.read | avs_req_in.write;
    access = req_act & st_reg.bus_done;
    idx = avs_req_in.address[4:2];
    wdat = avs_req_in.writedata[7:0];
    wr_en = access & avs_req_in.write & avs_req_in.byteenable[0];
    mode = t8pw_mode_t'({st_reg.ctrl[WGM_HIGH_BIT], st_reg.ctrl[WGM_LOW_BIT]});
    act = t8pw_act_t'(st_reg.ctrl[COM_HI_BIT:COM_LO_BIT]);
    at_max = st_reg.count == COUNT_MAX;
    at_zero = st_reg.count == COUNT_BOTTOM;
    match = (st_reg.count == st_reg.cmp_act) & ~st_reg.block_match;
    up_eff = at_zero | ~st_reg.dir_down;
    ovf_set = 1'b0;
    cmf_set = 1'b0;

    st_next.osc_s1 = osc_clk_in;
    st_next.osc_s2 = st_reg.osc_s1;
    st_next.osc_s3 = st_reg.osc_s2;

    // One wait state: read data is captured in the first cycle and
    // presented while waitrequest is low in the second.
    st_next.bus_done = req_act & ~st_reg.bus_done;
    if (req_act & ~st_reg.bus_done)
    begin
      st_next.rdata = 32'h0000_0000;
      case (idx)
        CTRL_OFS[4:2]:
        begin
          st_next.rdata[7:0] = st_reg.ctrl;
        end
        COUNT_OFS[4:2]:
        begin
          st_next.rdata[7:0] = st_reg.count;
        end
        CMP_OFS[4:2]:
        begin
          st_next.rdata[7:0] = st_reg.cmp_buf;
        end
        FLAG_OFS[4:2]:
        begin
          st_next.rdata[FLAG_OVF_BIT] = st_reg.ovf;
          st_next.rdata[FLAG_CMF_BIT] = st_reg.cmf;
        end
        CFG_OFS[4:2]:
        begin
          st_next.rdata[CFG_ASYNC_BIT] = st_reg.async_sel;
        end
        default:
        begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (timer_tick)
    begin
      st_next.block_match = 1'b0;
      cmf_set = match;
      case (mode)
        MODE_NORMAL:
        begin
          st_next.count = st_reg.count + COUNT_STEP;
          ovf_set = at_max;
          if (match)
          begin
            st_next.oc = act_result(act, st_reg.oc);
          end
        end
        MODE_CTC:
        begin
          // Top is the live compare value, so a late write can miss it.
          if (st_reg.count == st_reg.cmp_act)
          begin
            st_next.count = COUNT_BOTTOM;
          end
          else
          begin
            st_next.count = st_reg.count + COUNT_STEP;
          end
          ovf_set = at_max;
          if (match)
          begin
            st_next.oc = act_result(act, st_reg.oc);
          end
        end
        MODE_FAST:
        begin
          st_next.count = st_reg.count + COUNT_STEP;
          ovf_set = at_max;
          if (at_max)
          begin
            st_next.cmp_act = st_reg.cmp_buf;
          end
          if (act == ACT_TOGGLE)
          begin
            if (match)
            begin
              st_next.oc = ~st_reg.oc;
            end
          end
          else if (at_max)
          begin
            // A match at top is ignored here, so a compare of max
            // gives a constant level and zero gives a one-tick spike.
            st_next.oc = (act == ACT_CLEAR);
          end
          else if (match)
          begin
            st_next.oc = (act == ACT_SET);
          end
        end
        MODE_PHASE:
        begin
          if (st_reg.dir_down)
          begin
            if (at_zero)
            begin
              st_next.count = COUNT_BOTTOM + COUNT_STEP;
              st_next.dir_down = 1'b0;
            end
            else
            begin
              st_next.count = st_reg.count - COUNT_STEP;
            end
          end
          else
          begin
            if (at_max)
            begin
              st_next.count = COUNT_MAX - COUNT_STEP;
              st_next.dir_down = 1'b1;
            end
            else
            begin
              st_next.count = st_reg.count + COUNT_STEP;
            end
          end
          ovf_set = at_zero;
          if (at_max)
          begin
            st_next.cmp_act = st_reg.cmp_buf;
            if (st_reg.ctrl[COM_HI_BIT])
            begin
              if (st_reg.cmp_buf == COUNT_MAX)
              begin
                st_next.oc = (act == ACT_CLEAR);
              end
              else
              begin
                st_next.oc = (act == ACT_SET);
              end
            end
          end
          else if (match & st_reg.ctrl[COM_HI_BIT])
          begin
            // Bottom counts as the start of the up slope, which keeps
            // a compare of zero at a constant level.
            if (up_eff)
            begin
              st_next.oc = (act == ACT_SET);
            end
            else
            begin
              st_next.oc = (act == ACT_CLEAR);
            end
          end
        end
        default:
        begin
          st_next.count = st_reg.count;
        end
      endcase
    end

    if (mode != MODE_PHASE)
    begin
      st_next.dir_down = 1'b0;
    end

    if (wr_en)
    begin
      case (idx)
        CTRL_OFS[4:2]:
        begin
          st_next.ctrl = {1'b0, wdat[6:0]};
          // Both non-PWM modes have the low mode bit clear.
          if (wdat[FORCE_BIT] & ~wdat[WGM_LOW_BIT])
          begin
            st_next.oc = act_result(t8pw_act_t'(wdat[COM_HI_BIT:COM_LO_BIT]),
              st_next.oc);
          end
        end
        COUNT_OFS[4:2]:
        begin
          st_next.count = wdat;
          st_next.block_match = 1'b1;
        end
        CMP_OFS[4:2]:
        begin
          st_next.cmp_buf = wdat;
          if (~st_reg.ctrl[WGM_LOW_BIT])
          begin
            st_next.cmp_act = wdat;
          end
        end
        CFG_OFS[4:2]:
        begin
          st_next.async_sel = wdat[CFG_ASYNC_BIT];
        end
        default:
        begin
          st_next.async_sel = st_next.async_sel;
        end
      endcase
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    flag_wr = wr_en & (idx == FLAG_OFS[4:2]);
    ovf_clr = overflow_ack_in | (flag_wr & wdat[FLAG_OVF_BIT]);
    cmf_clr = compare_ack_in | (flag_wr & wdat[FLAG_CMF_BIT]);
    st_next.ovf = ovf_set | (st_reg.ovf & ~ovf_clr);
    st_next.cmf = cmf_set | (st_reg.cmf & ~cmf_clr);

    st_next.pin_en = st_next.ctrl[COM_HI_BIT:COM_LO_BIT] != 2'h0;
    if (st_next.pin_en)
    begin
      st_next.pin = st_next.oc;
    end
    else
    begin
      st_next.pin = port_data_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_out = st_reg.rdata;
  assign avs_waitrequest_out = req_act & ~st_reg.bus_done;
  assign compare_output_pin_out = st_reg.pin;
  assign compare_output_en_out = st_reg.pin_en;
  assign overflow_flag_out = st_reg.ovf;
  assign compare_match_flag_out = st_reg.cmf;
endmodule

// *** test/t8pw_load.sv ***
// Load on the waveform pin that measures high time and period in clocks.
`timescale 1ns/1ps
module t8pw_load
(
  input wire logic ref_clk_in,
  input wire logic pin_in,
  output logic [15:0] high_len_out,
  output logic [15:0] period_out,
  output logic [7:0] rises_out
);
  logic prev;
  logic [15:0] since;
  logic [15:0] hcnt;
  initial
  begin
    prev = 1'b1;
    since = 16'h0;
    hcnt = 16'h0;
    high_len_out = 16'h0;
    period_out = 16'h0;
    rises_out = 8'h0;
  end
  always @(posedge ref_clk_in)
  begin
    prev <= pin_in;
    if (pin_in && !prev)
    begin
      period_out <= since;
      since <= 16'h1;
      hcnt <= 16'h1;
      rises_out <= rises_out + 8'h1;
    end
    else
    begin
      since <= since + 16'h1;
      hcnt <= hcnt + {15'h0, pin_in};
      if (!pin_in && prev)
        high_len_out <= hcnt;
    end
  end
endmodule

// *** test/t8pw_monitor.sv ***
// Port checker of the 8-bit PWM timer, bound to its top module.
`timescale 1ns/1ps
module t8pw_monitor
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire t8pw_pkg::t8pw_avs_req_t avs_req_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic port_data_in,
  input wire logic overflow_ack_in,
  input wire logic compare_ack_in,
  input wire logic compare_output_pin_out,
  input wire logic compare_output_en_out,
  input wire logic overflow_flag_out,
  input wire logic compare_match_flag_out
);
  import t8pw_pkg::*;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);
  logic req;
  logic acc;
  logic flag_wr;
  logic ctrl_wr;
  logic en_exp_reg;
  assign req = avs_req_in.read | avs_req_in.write;
  assign acc = req & !avs_waitrequest_out;
  assign flag_wr = acc & avs_req_in.write & (avs_req_in.address == FLAG_OFS);
  assign ctrl_wr = acc & avs_req_in.write & avs_req_in.byteenable[0]
    & (avs_req_in.address == CTRL_OFS);
  // The expected enable is held here because the request is gone when it shows.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      en_exp_reg <= 1'b0;
    else if (ctrl_wr)
      en_exp_reg <= (avs_req_in.writedata[5:4] != 2'h0);
  end
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("request not stalled in its first cycle");
  a_wait_once: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait state");
  a_force_reads_zero: assert property (
    acc && avs_req_in.read |-> avs_readdata_out[31:8] == 24'h0
    && !(avs_req_in.address == CTRL_OFS && avs_readdata_out[FORCE_BIT]))
    else $error("force bit or upper bits read as one");
  a_en_follows_action: assert property (
    ctrl_wr |-> ##2 compare_output_en_out == en_exp_reg)
    else $error("pin enable does not follow action field");
  a_port_passthru: assert property (
    !$past(srst_in) && !compare_output_en_out && !$past(compare_output_en_out)
    |-> compare_output_pin_out == $past(port_data_in))
    else $error("pin does not follow port data");
  a_ovf_sticky: assert property (
    overflow_flag_out && !overflow_ack_in && !flag_wr |=> overflow_flag_out)
    else $error("overflow flag dropped without clear");
  a_cmp_sticky: assert property (
    compare_match_flag_out && !compare_ack_in && !flag_wr |=> compare_match_flag_out)
    else $error("compare flag dropped without clear");
  a_ovf_clear_cause: assert property (
    !$past(srst_in) && $fell(overflow_flag_out) |-> $past(overflow_ack_in) || $past(flag_wr))
    else $error("overflow flag cleared without cause");
  c_ovf: cover property ($rose(overflow_flag_out));
  c_cmf: cover property ($rose(compare_match_flag_out));
  c_pin: cover property ($rose(compare_output_pin_out) && compare_output_en_out);
endmodule

bind t8pw_top t8pw_monitor u_mon (.ref_clk_in, .srst_in, .avs_req_in, .avs_readdata_out,
  .avs_waitrequest_out, .port_data_in, .overflow_ack_in, .compare_ack_in,
  .compare_output_pin_out, .compare_output_en_out, .overflow_flag_out,
  .compare_match_flag_out);

// *** test/test_t8pw_top.sv ***
// Self-checking bench of the 8-bit PWM timer.
`timescale 1ns/1ps
module test_t8pw_top;
  import t8pw_pkg::*;
  logic ref_clk_in;
  logic srst_in;
  t8pw_avs_req_t req;
  logic [31:0] rdata;
  logic wait_req;
  logic port_data;
  logic osc_clk;
  logic ovf_ack;
  logic cmp_ack;
  logic pin;
  logic pin_en;
  logic ovf;
  logic cmf;
  logic [15:0] high_len;
  logic [15:0] period;
  logic [7:0] rises;
  logic [31:0] rd;
  int error_cnt;
  int check_count;

  t8pw_top u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .avs_req_in(req),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .osc_clk_in(osc_clk),
    .port_data_in(port_data), .overflow_ack_in(ovf_ack), .compare_ack_in(cmp_ack),
    .compare_output_pin_out(pin), .compare_output_en_out(pin_en),
    .overflow_flag_out(ovf), .compare_match_flag_out(cmf));
  t8pw_load u_load (.ref_clk_in(ref_clk_in), .pin_in(pin), .high_len_out(high_len),
    .period_out(period), .rises_out(rises));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // The oscillator edges fall between clock edges, one rise every five clocks.
  initial
  begin
    osc_clk = 1'b0;
    #1;
    forever #10 osc_clk = ~osc_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low; the watchdog ends a hang.
  task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
    @(posedge ref_clk_in);
    req.address <= addr;
    req.read <= !wr;
    req.write <= wr;
    req.byteenable <= 4'h1;
    req.writedata <= data;
    do
      @(posedge ref_clk_in);
    while (wait_req !== 1'b0);
    rd = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic test_regs;
    bus(1'b0, CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    port_data <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check("port pin", pin, 1'b0);
    port_data <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    check("port pin", pin, 1'b1);
    bus(1'b0, COUNT_OFS, 32'h0);
    check("stopped count", rd, 32'h0);
    $display("regs done");
  endtask

  task automatic test_force;
    logic [7:0] ctl [4];
    logic exp [4];
    ctl = '{8'hB0, 8'hA0, 8'h90, 8'h90};
    exp = '{1'b1, 1'b0, 1'b1, 1'b0};
    bus(1'b1, CMP_OFS, 32'h80);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, CTRL_OFS, {24'h0, ctl[i]});
      repeat (3) @(posedge ref_clk_in);
      check("forced pin", pin, exp[i]);
    end
    check("pin enable", pin_en, 1'b1);
    bus(1'b0, CTRL_OFS, 32'h0);
    check("ctrl read", rd, 32'h10);
    bus(1'b0, FLAG_OFS, 32'h0);
    check("flags after force", rd, 32'h0);
    $display("force done");
  endtask

  task automatic wave(input logic [7:0] cmp, input logic [7:0] ctl, input logic [15:0] hi,
    input logic [15:0] per, input logic [31:0] flg);
    logic [7:0] r0;
    int n;
    bus(1'b1, CMP_OFS, {24'h0, cmp});
    bus(1'b1, CTRL_OFS, {24'h0, ctl});
    bus(1'b1, FLAG_OFS, 32'h3);
    r0 = rises;
    n = 0;
    while (8'(rises - r0) < 8'h4 && n < 6000)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 6000)
      error_cnt++;
    check("high time", high_len, hi);
    check("period", period, per);
    bus(1'b0, FLAG_OFS, 32'h0);
    check("flags", rd, flg);
    $display("wave %h done", ctl);
  endtask

  // A compare of max in fast PWM, or of zero or max in phase PWM, must leave the pin at one level with no edges.
  task automatic test_hold(input logic [7:0] cmp, input logic [7:0] ctl, input logic exp);
    logic [7:0] r0;
    bus(1'b1, CMP_OFS, {24'h0, cmp});
    bus(1'b1, CTRL_OFS, {24'h0, ctl});
    repeat (1100) @(posedge ref_clk_in);
    r0 = rises;
    repeat (520) @(posedge ref_clk_in);
    check("held rises", rises, r0);
    check("held level", pin, exp);
    $display("hold %h done", ctl);
  endtask

  // Clear-on-match toggling from the divided clock, then from the oscillator.
  task automatic test_ctc;
    bus(1'b1, COUNT_OFS, 32'h0);
    wave(8'h0F, 8'h1A, 16'h80, 16'h100, 32'h2);
    bus(1'b1, CTRL_OFS, 32'h0);
    bus(1'b1, COUNT_OFS, 32'h0);
    bus(1'b1, CFG_OFS, 32'h1);
    wave(8'h03, 8'h19, 16'h14, 16'h28, 32'h2);
    $display("ctc done");
  endtask

  task automatic test_ack;
    bus(1'b1, CTRL_OFS, 32'h0);
    check("held flag", ovf, 1'b1);
    ovf_ack <= 1'b1;
    cmp_ack <= 1'b1;
    @(posedge ref_clk_in);
    ovf_ack <= 1'b0;
    cmp_ack <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    check("acked flags", {ovf, cmf}, 2'h0);
    $display("ack done");
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk_in);
    error_cnt++;
    $display("watchdog expired");
    end_sim;
  end

  initial
  begin
    srst_in = 1'b1;
    req = '0;
    port_data = 1'b1;
    ovf_ack = 1'b0;
    cmp_ack = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    test_regs;
    test_force;
    wave(8'h40, 8'h69, 16'h41, 16'h100, 32'h3);
    wave(8'h40, 8'h79, 16'hBF, 16'h100, 32'h3);
    wave(8'h00, 8'h69, 16'h1, 16'h100, 32'h3);
    wave(8'h40, 8'h59, 16'h100, 16'h200, 32'h3);
    wave(8'h40, 8'h61, 16'h80, 16'h1FE, 32'h3);
    wave(8'h40, 8'h71, 16'h17E, 16'h1FE, 32'h3);
    test_hold(8'hFF, 8'h69, 1'b1);
    test_hold(8'h00, 8'h61, 1'b0);
    test_hold(8'hFF, 8'h61, 1'b1);
    test_ack;
    test_ctc;
    end_sim;
  end
endmodule
